//--- hdl/plu_predicate_logic_unit.sv
// Purpose: bitwise logical operations on predicate registers
// Assumes: issuing pipeline runs on clock_i; single-stage answer
// Notes: register port has no wait states; read data one cycle late
//
// Functional notes
// - every predicate bit is its own element
// - flags from result; V always zero
// - inactive destination bits written as zero
// - flag check writes no destination, flags only
// - conjunction, plain and flag-setting
// - bit clear a and not b, both forms
// - exclusive or, plain and flag-setting
// - nand then mask inactive bits, both forms
// - nor then mask inactive bits, both forms
`timescale 1ns/1ps

module plu_predicate_logic_unit
(
	// clock and reset
	input wire logic clock_i,
	input wire logic nrst_i,

	// instruction issue
	input wire plu_pkg::plu_req_type req_i,

	// instruction answer
	output plu_pkg::plu_res_type res_o,

	// register port
	input wire logic [plu_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [plu_pkg::DATA_W-1:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	output logic [plu_pkg::DATA_W-1:0] reg_rdata_o
);

	// ************************************************************
	// flag helpers
	// ************************************************************

	// lowest-numbered active element of the result
	function automatic logic first_active(input logic [plu_pkg::PRED_W-1:0] res,
		input logic [plu_pkg::PRED_W-1:0] gov);
		logic found;
		logic bit_val;
		found = 1'b0;
		bit_val = 1'b0;
		for (int i = 0; i < plu_pkg::PRED_W; i++)
		begin
			if (!found && gov[i])
			begin
				found = 1'b1;
				bit_val = res[i];
			end
		end
		return bit_val;
	endfunction

	// highest-numbered active element of the result
	function automatic logic last_active(input logic [plu_pkg::PRED_W-1:0] res,
		input logic [plu_pkg::PRED_W-1:0] gov);
		logic found;
		logic bit_val;
		found = 1'b0;
		bit_val = 1'b0;
		for (int i = plu_pkg::PRED_W - 1; i >= 0; i--)
		begin
			if (!found && gov[i])
			begin
				found = 1'b1;
				bit_val = res[i];
			end
		end
		return bit_val;
	endfunction

	// ************************************************************
	// control and status state
	// ************************************************************
	logic enable;
	logic next_enable;
	logic bad_op;
	logic next_bad_op;
	logic [plu_pkg::CNT_W-1:0] op_count;
	logic [plu_pkg::CNT_W-1:0] next_op_count;
	plu_pkg::plu_flags_type last_flags;
	plu_pkg::plu_flags_type next_last_flags;
	logic [plu_pkg::DATA_W-1:0] next_reg_rdata;

	// ************************************************************
	// datapath
	// ************************************************************
	logic [plu_pkg::PRED_W-1:0] raw_bits;
	logic [plu_pkg::PRED_W-1:0] masked_bits;
	logic op_legal;
	logic take;
	plu_pkg::plu_op_type op_code;
	plu_pkg::plu_flags_type calc_flags;
	plu_pkg::plu_res_type next_res;

	assign op_code = plu_pkg::plu_op_type'(req_i.op);

	// per element: operate, then zero inactive bits
	genvar g;
	generate
		for (g = 0; g < plu_pkg::PRED_W; g++)
		begin : elem
			logic a;
			logic b;
			logic r;
			assign a = req_i.src_a[g];
			assign b = req_i.src_b[g];
			always_comb
			begin
				unique case (req_i.op)
					3'h0: r = a & b;
					3'h1: r = a & ~b;
					3'h2: r = a ^ b;
					3'h3: r = ~(a & b);
					3'h4: r = ~(a | b);
					3'h5: r = a;
					default: r = 1'b0;
				endcase
			end
			assign raw_bits[g] = r;
			// active exactly when the governing bit is one
			assign masked_bits[g] = raw_bits[g] & req_i.gov[g];
		end
	endgenerate

	always_comb
	begin
		unique case (op_code)
			plu_pkg::conjunction_op,
			plu_pkg::bit_clear_op,
			plu_pkg::exclusive_or_op,
			plu_pkg::not_conjunction_op,
			plu_pkg::not_disjunction_op,
			plu_pkg::predicate_flag_check: op_legal = 1'b1;
			default: op_legal = 1'b0;
		endcase
	end

	// illegal codes are dropped, not answered
	assign take = req_i.valid && enable && op_legal;

	// flags look only at active elements
	always_comb
	begin
		// a non-canonical governing predicate is the issuer's fault
		calc_flags.n = first_active(masked_bits, req_i.gov);
		calc_flags.z = ~|masked_bits;
		calc_flags.c = ~last_active(masked_bits, req_i.gov);
		calc_flags.v = 1'b0;
	end

	always_comb
	begin
		next_res = '0;
		next_res.flags = res_o.flags;
		if (take)
		begin
			next_res.valid = 1'b1;
			if (op_code == plu_pkg::predicate_flag_check)
			begin
				// test leaves destination alone, data held at zero
				next_res.dest_write = 1'b0;
				next_res.data = '0;
				next_res.flags_valid = 1'b1;
				next_res.flags = calc_flags;
			end
			else
			begin
				next_res.dest_write = 1'b1;
				next_res.data = masked_bits;
				next_res.flags_valid = req_i.set_flags;
				if (req_i.set_flags)
				begin
					next_res.flags = calc_flags;
				end
			end
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			res_o <= '0;
		end
		else
		begin
			res_o <= next_res;
		end
	end

	// ************************************************************
	// register port
	// ************************************************************
	logic wr_ctrl;
	logic wr_status;
	logic wr_count;

	assign wr_ctrl = reg_write_i && (reg_addr_i == plu_pkg::REG_CTRL);
	assign wr_status = reg_write_i && (reg_addr_i == plu_pkg::REG_STATUS);
	assign wr_count = reg_write_i && (reg_addr_i == plu_pkg::REG_COUNT);

	always_comb
	begin
		next_enable = enable;
		if (wr_ctrl)
		begin
			next_enable = reg_wdata_i[plu_pkg::CTRL_ENABLE_BIT];
		end
	end

	// sticky error: a new bad code wins over a write-one clear
	always_comb
	begin
		next_bad_op = bad_op;
		if (wr_status && reg_wdata_i[plu_pkg::STAT_BAD_OP_BIT])
		begin
			next_bad_op = 1'b0;
		end
		if (req_i.valid && enable && !op_legal)
		begin
			next_bad_op = 1'b1;
		end
	end

	// counter wraps; a write reloads it, an op in the same cycle loses
	always_comb
	begin
		next_op_count = op_count;
		if (take)
		begin
			next_op_count = op_count + 16'h0001;
		end
		if (wr_count)
		begin
			next_op_count = reg_wdata_i[plu_pkg::CNT_W-1:0];
		end
	end

	always_comb
	begin
		next_last_flags = last_flags;
		if (take && (req_i.set_flags || op_code == plu_pkg::predicate_flag_check))
		begin
			next_last_flags = calc_flags;
		end
	end

	// unmapped offsets read as zero
	always_comb
	begin
		next_reg_rdata = '0;
		if (reg_read_i)
		begin
			unique case (reg_addr_i)
				plu_pkg::REG_CTRL:
				begin
					next_reg_rdata[plu_pkg::CTRL_ENABLE_BIT] = enable;
				end
				plu_pkg::REG_STATUS:
				begin
					next_reg_rdata[plu_pkg::STAT_FLAGS_LSB +: 4] = last_flags;
					next_reg_rdata[plu_pkg::STAT_BAD_OP_BIT] = bad_op;
					next_reg_rdata[plu_pkg::STAT_BUSY_BIT] = res_o.valid;
				end
				plu_pkg::REG_COUNT:
				begin
					next_reg_rdata[plu_pkg::CNT_W-1:0] = op_count;
				end
				default:
				begin
					next_reg_rdata = '0;
				end
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			enable <= plu_pkg::CTRL_ENABLE_RST;
			bad_op <= 1'b0;
			op_count <= plu_pkg::COUNT_RST;
			last_flags <= plu_pkg::FLAGS_RST;
			reg_rdata_o <= '0;
		end
		else
		begin
			enable <= next_enable;
			bad_op <= next_bad_op;
			op_count <= next_op_count;
			last_flags <= next_last_flags;
			reg_rdata_o <= next_reg_rdata;
		end
	end

endmodule

//--- hdl/plu_pkg.sv
// Purpose: shared constants and types of the predicate logic unit
// Assumes: one predicate bit per element, fixed width below
// Notes: register offsets are byte addresses on the plain port

// ************************************************************
// package
// ************************************************************
package plu_pkg;

	// predicate width in bits (one bit per element)
	localparam int PRED_W = 16;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam int CNT_W = 16;

	// register offsets
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_COUNT = 4'h8;

	// control fields
	localparam int CTRL_ENABLE_BIT = 0;
	localparam logic CTRL_ENABLE_RST = 1'h1;

	// status fields
	localparam int STAT_FLAGS_LSB = 0;
	localparam int STAT_BAD_OP_BIT = 4;
	localparam int STAT_BUSY_BIT = 5;

	localparam logic [CNT_W-1:0] COUNT_RST = 16'h0000;

	// operation codes
	typedef enum logic [2:0]
	{
		conjunction_op = 3'h0,
		bit_clear_op = 3'h1,
		exclusive_or_op = 3'h2,
		not_conjunction_op = 3'h3,
		not_disjunction_op = 3'h4,
		predicate_flag_check = 3'h5
	} plu_op_type;

	// condition flags, msb first
	typedef struct packed
	{
		logic n;
		logic z;
		logic c;
		logic v;
	} plu_flags_type;

	localparam plu_flags_type FLAGS_RST = 4'h0;

	// one issued predicate instruction
	typedef struct packed
	{
		logic valid;
		logic [2:0] op;
		logic set_flags;
		logic [PRED_W-1:0] gov;
		logic [PRED_W-1:0] src_a;
		logic [PRED_W-1:0] src_b;
	} plu_req_type;

	// one produced answer
	typedef struct packed
	{
		logic valid;
		logic dest_write;
		logic [PRED_W-1:0] data;
		logic flags_valid;
		plu_flags_type flags;
	} plu_res_type;

endpackage

//--- dv/plu_issuer.sv
// Purpose: pipeline model that issues predicate instructions
// Assumes: one instruction per call, launched after a clock edge
// Notes: gap 0 keeps valid high for back-to-back issue
`timescale 1ns/1ps

module plu_issuer
(
	// clock
	input wire logic clock_i,

	// issue side
	output plu_pkg::plu_req_type req_o
);
	initial req_o = '0;

	// ********
	// issue
	// ********
	// released lines show inverted data so stale values never match
	task automatic issue(input plu_pkg::plu_req_type r, input int gap);
		@(posedge clock_i);
		req_o <= r;
		if (gap > 0)
		begin
			@(posedge clock_i);
			req_o <= {1'b0, ~r[$bits(r)-2:0]};
			repeat (gap - 1) @(posedge clock_i);
		end
	endtask
endmodule

//--- dv/plu_predicate_logic_unit_asserts.sv
// Purpose: concurrent checks on the predicate answer
// Assumes: answer stands one cycle after its request
// Notes: q holds the request that the current answer belongs to
`timescale 1ns/1ps

module plu_predicate_logic_unit_asserts
(
	// clock and reset
	input wire logic clock_i,
	input wire logic nrst_i,

	// watched ports
	input wire plu_pkg::plu_req_type req_i,
	input wire plu_pkg::plu_res_type res_o
);
	plu_pkg::plu_req_type q;
	logic [15:0] r;

	always_ff @(posedge clock_i)
		q <= req_i;

	// test op has no data, so flags come from a and gov
	assign r = (q.op == 3'h5) ? (q.src_a & q.gov) : res_o.data;

	// expected n and c: result at lowest active element, inverted result at highest
	logic exp_n;
	logic exp_c;
	always_comb
	begin
		exp_n = 1'b0;
		exp_c = 1'b1;
		for (int i = plu_pkg::PRED_W - 1; i >= 0; i--)
			if (q.gov[i])
				exp_n = r[i];
		for (int i = 0; i < plu_pkg::PRED_W; i++)
			if (q.gov[i])
				exp_c = ~r[i];
	end

	default clocking @(posedge clock_i); endclocking
	default disable iff (!nrst_i);

	// ********
	// checks
	// ********
	chk_flag_value: assert property (res_o.flags_valid |-> !res_o.flags.v && res_o.flags.z == (r == 16'h0))
		else $error("flag value wrong");
	chk_flag_ends: assert property (res_o.flags_valid |-> res_o.flags.n == exp_n && res_o.flags.c == exp_c)
		else $error("n or c flag wrong");
	chk_flags_hold: assert property (!res_o.flags_valid |-> $stable(res_o.flags))
		else $error("flags changed without update");
	chk_test_nowrite: assert property (res_o.valid |-> res_o.dest_write == (q.op != 3'h5))
		else $error("dest write wrong");
	chk_test_nodata: assert property (res_o.valid && q.op == 3'h5 |-> res_o.data == 16'h0)
		else $error("test op gave data");
	chk_inactive_zero: assert property (res_o.valid |-> (res_o.data & ~q.gov) == 16'h0)
		else $error("inactive bit set");
	chk_conj_data: assert property (res_o.valid && q.op == 3'h0 |-> res_o.data == (q.src_a & q.src_b & q.gov))
		else $error("conjunction wrong");
	chk_clear_data: assert property (res_o.valid && q.op == 3'h1 |-> res_o.data == (q.src_a & ~q.src_b & q.gov))
		else $error("bit clear wrong");
	chk_xor_data: assert property (res_o.valid && q.op == 3'h2 |-> res_o.data == ((q.src_a ^ q.src_b) & q.gov))
		else $error("exclusive or wrong");
	chk_nand_data: assert property (res_o.valid && q.op == 3'h3 |-> res_o.data == (~(q.src_a & q.src_b) & q.gov))
		else $error("nand wrong");
	chk_nor_data: assert property (res_o.valid && q.op == 3'h4 |-> res_o.data == (~(q.src_a | q.src_b) & q.gov))
		else $error("nor wrong");
endmodule

bind plu_predicate_logic_unit plu_predicate_logic_unit_asserts u_chk
(
	.clock_i(clock_i),
	.nrst_i(nrst_i),
	.req_i(req_i),
	.res_o(res_o)
);

//--- dv/plu_predicate_logic_unit_tb.sv
// Purpose: self-checking bench of the predicate logic unit
// Assumes: issuer model drives requests, bench drives registers
// Notes: expected answers wait in a queue for the monitor
`timescale 1ns/1ps

module plu_predicate_logic_unit_tb;
	logic clock_i;
	logic nrst_i;
	logic [3:0] addr;
	logic [31:0] wdata;
	logic wr_s;
	logic rd_s;
	logic [31:0] rdata;
	logic [15:0] cnt;
	plu_pkg::plu_req_type req;
	plu_pkg::plu_res_type res;
	plu_pkg::plu_res_type expq[$];
	plu_pkg::plu_flags_type fl;
	int mismatches;
	int compares;

	plu_issuer u_iss(.clock_i(clock_i), .req_o(req));
	plu_predicate_logic_unit u_dut(.clock_i(clock_i), .nrst_i(nrst_i), .req_i(req), .res_o(res),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_write_i(wr_s), .reg_read_i(rd_s), .reg_rdata_o(rdata));

	// ********
	// helpers
	// ********
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic test_done();
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	function automatic plu_pkg::plu_res_type model(input plu_pkg::plu_req_type r);
		plu_pkg::plu_res_type e;
		logic [15:0] v;
		int lo;
		int hi;
		case (r.op)
			3'h0: v = r.src_a & r.src_b;
			3'h1: v = r.src_a & ~r.src_b;
			3'h2: v = r.src_a ^ r.src_b;
			3'h3: v = ~(r.src_a & r.src_b);
			3'h4: v = ~(r.src_a | r.src_b);
			default: v = r.src_a;
		endcase
		v = v & r.gov;
		lo = -1;
		hi = -1;
		for (int i = 15; i >= 0; i--)
			if (r.gov[i])
				lo = i;
		for (int i = 0; i < 16; i++)
			if (r.gov[i])
				hi = i;
		e = '0;
		e.valid = 1'b1;
		e.dest_write = (r.op != 3'h5);
		e.data = e.dest_write ? v : 16'h0000;
		e.flags_valid = r.set_flags | ~e.dest_write;
		if (e.flags_valid)
			fl = {(lo < 0) ? 1'b0 : v[lo], v == 16'h0, (hi < 0) ? 1'b1 : ~v[hi], 1'b0};
		e.flags = fl;
		return e;
	endfunction

	task automatic send(input logic [2:0] op, input logic sf, input logic [15:0] g, input int gap, input logic take);
		plu_pkg::plu_req_type r;
		r = {1'b1, op, sf, g, 16'($urandom), 16'($urandom)};
		if (take)
		begin
			expq.push_back(model(r));
			cnt++;
		end
		u_iss.issue(r, gap);
	endtask

	task automatic wreg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock_i);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clock_i);
		wr_s <= 1'b0;
	endtask

	task automatic rreg(input logic [3:0] a, input logic [31:0] e);
		@(posedge clock_i);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clock_i);
		rd_s <= 1'b0;
		#1;
		check(rdata, e);
	endtask

	// ********
	// clock, monitor, watchdog
	// ********
	initial
	begin
		clock_i = 1'b0;
		forever #12.5 clock_i = ~clock_i;
	end

	always @(negedge clock_i)
		if (res.valid === 1'b1)
			check(res, (expq.size() > 0) ? expq.pop_front() : 64'h0);

	initial
	begin
		#100000;
		mismatches++;
		test_done();
	end

	// ********
	// tests
	// ********
	initial
	begin
		nrst_i = 1'b0;
		addr = 4'h0;
		wdata = 32'h0;
		wr_s = 1'b0;
		rd_s = 1'b0;
		fl = '0;
		cnt = 16'h0;
		mismatches = 0;
		compares = 0;
		void'($urandom(32'h184b));
		repeat (8) @(posedge clock_i);
		nrst_i <= 1'b1;
		rreg(4'h0, 32'h1);
		for (int k = 0; k < 24; k++)
			send(3'(k % 6), k >= 6 && k < 18, (k % 4 == 0) ? 16'h0 : (k % 4 == 1) ? 16'hffff : 16'($urandom), k % 3, 1'b1);
		rreg(4'h8, 32'(cnt));
		rreg(4'h4, 32'(fl));
		wreg(4'h0, 32'h0);
		send(3'h0, 1'b1, 16'hffff, 2, 1'b0);
		wreg(4'h0, 32'h1);
		send(3'h6, 1'b1, 16'hffff, 2, 1'b0);
		rreg(4'h4, 32'h10 | 32'(fl));
		wreg(4'h4, 32'h10);
		rreg(4'h4, 32'(fl));
		wreg(4'h8, 32'hffff);
		cnt = 16'hffff;
		send(3'h5, 1'b0, 16'h8001, 2, 1'b1);
		rreg(4'h8, 32'(cnt));
		rreg(4'hc, 32'h0);
		// status read lands while an answer stands, so busy shows high
		fork
			send(3'h2, 1'b1, 16'hffff, 2, 1'b1);
			begin
				@(posedge clock_i);
				rreg(4'h4, 32'h20 | 32'(fl));
			end
		join
		repeat (3) @(posedge clock_i);
		check(expq.size(), 64'h0);
		test_done();
	end
endmodule
